// file: common/debi_regs.vh
// constants of the external bus interface
`ifndef DEBI_REGS_VH
`define DEBI_REGS_VH
`define DEBI_DW 16
`define DEBI_AW 16
`define DEBI_PORT_AW 4
`define DEBI_PORT_N 16
`define DEBI_PH_Q1 2'h0
`define DEBI_PH_Q2 2'h1
`define DEBI_PH_Q3 2'h2
`define DEBI_PH_Q4 2'h3
`define DEBI_HM_RESET 1'h1
`define DEBI_SP_PROG 2'h0
`define DEBI_SP_DATA 2'h1
`define DEBI_SP_IO 2'h2
`define DEBI_SP_NONE 2'h3
`define DEBI_SYNC_ONES 3'h7
`define DEBI_NEED_ONE 2'h1
`define DEBI_NEED_TWO 2'h2
`endif

// file: verilog/debi_phase_gen.v
// four-phase machine cycle generator and phase clock outputs
`include "debi_regs.vh"
module debi_phase_gen (
   input wire i_clk,
   input wire i_rst_n,
   output wire [1:0] o_phase,
   output wire o_cycle_end,
   output reg o_phase_clock_out_a,
   output reg o_phase_clock_out_b
);
   reg [1:0] ph_q;
   assign o_phase = ph_q;
   assign o_cycle_end = (ph_q == `DEBI_PH_Q4);
   // phase clocks are registered so they carry no decode glitches
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ph_q <= `DEBI_PH_Q1;
         o_phase_clock_out_a <= 1'b0;
         o_phase_clock_out_b <= 1'b0;
      end else begin
         ph_q <= ph_q + 2'h1; // see R20
         // a high in q2,q3; b high in q3,q4: the pair names the phase
         o_phase_clock_out_a <= (ph_q == `DEBI_PH_Q1) ||
                                (ph_q == `DEBI_PH_Q2);
         o_phase_clock_out_b <= (ph_q == `DEBI_PH_Q2) ||
                                (ph_q == `DEBI_PH_Q3);
      end
   end
endmodule

// file: verilog/debi_sync3.v
// three-stage synchroniser with second/third stage agreement filter
module debi_sync3 (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_rst_val,
   input wire i_async,
   output reg o_level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge i_clk) begin
      // reset to the pin's idle level, so no false request follows reset
      if (!i_rst_n) begin
         s1_q <= i_rst_val;
         s2_q <= i_rst_val;
         s3_q <= i_rst_val;
         o_level <= i_rst_val;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end
endmodule

// file: verilog/debi_bus_if.v
// external memory and i/o bus interface with dormant modes
//
// Contract
// R1: dormant on idle, or hold low with halt bit
// R2: all internal state kept while dormant
// R3: hold-halt dormant floats every bus output
// R4: idle dormant floats only data lines
// R5: hold release or interrupt ends dormancy
// R6: 16-bit data and address buses
// R7: exactly one space select per access
// R8: direction and strobe drive each transfer
// R9: sixteen input and sixteen output ports
// R10: port op two cycles, one repeated
// R11: io uses shared bus, own select
// R12: on-chip access floats data, controls high
// R13: wait cycles inserted until ready
// R14: all on-chip runs without waits
// R15: on-chip program: in two, out one
// R16: external fetch waits only on ready
// R17: external data read at least two cycles
// R18: external data write one or two cycles
// R19: next fetch location changes cycle count
// R20: four phases, two phase clock outputs
// R21: halt bit set stops execution on hold
// R22: bus restored before access, no glitch
`include "debi_regs.vh"
module debi_bus_if (
   input wire i_clk,
   input wire i_rst_n,
   // core request: one per instruction, held until o_core_done
   input wire i_req,
   input wire [1:0] i_req_space,
   input wire i_req_write,
   input wire i_req_ext,
   input wire i_req_repeat,
   input wire i_fetch_ext,
   input wire [`DEBI_AW-1:0] i_req_addr,
   input wire [`DEBI_DW-1:0] i_req_wdata,
   input wire i_hold_halt_mode_bit,
   input wire i_idle,
   input wire i_interrupt,
   output wire o_core_ready,
   output reg o_core_done,
   output reg [`DEBI_DW-1:0] o_core_rdata,
   output wire o_exec_run,
   output wire o_dormant,
   // external pins
   input wire i_hold_n,
   input wire i_ready,
   input wire [`DEBI_DW-1:0] i_data_lines,
   output reg [`DEBI_DW-1:0] o_data_lines,
   output wire o_data_lines_oe,
   output reg [`DEBI_AW-1:0] o_address_lines,
   output wire o_address_lines_oe,
   output reg o_program_space_select_n,
   output reg o_data_space_select_n,
   output reg o_io_space_select_n,
   output reg o_transfer_strobe_n,
   output reg o_read_write,
   output wire o_ctrl_oe,
   output wire o_hold_ack_n,
   output wire o_phase_clock_out_a,
   output wire o_phase_clock_out_b
);
   localparam ST_RUN = 4'h1;
   localparam ST_XFER = 4'h2;
   localparam ST_IDLE = 4'h4;
   localparam ST_HOLD = 4'h8;

   wire [1:0] phase;
   wire cyc_end;
   wire hold_n_s;
   wire ready_s;

   debi_phase_gen u_ph (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .o_phase(phase),
      .o_cycle_end(cyc_end),
      .o_phase_clock_out_a(o_phase_clock_out_a),
      .o_phase_clock_out_b(o_phase_clock_out_b)
   );
   debi_sync3 u_hold (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_rst_val(1'b1),
      .i_async(i_hold_n),
      .o_level(hold_n_s)
   );
   debi_sync3 u_rdy (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_rst_val(1'b0),
      .i_async(i_ready),
      .o_level(ready_s)
   );

   reg [3:0] st_q;
   reg [1:0] cyc_q;
   reg [1:0] need_q;
   reg ext_q;
   reg drv_q;
   reg hold_seen_q;
   reg hold_halt_q;
   reg [1:0] need_d;
   reg [`DEBI_DW-1:0] rd_q;

   // cycles an instruction occupies, not counting ready waits
   always @* begin
      need_d = `DEBI_NEED_ONE; // see R14
      if (i_req_space == `DEBI_SP_IO) begin
         if (i_req_repeat) begin
            need_d = `DEBI_NEED_ONE; // see R10
         end else if (!i_fetch_ext && i_req_write) begin
            need_d = `DEBI_NEED_ONE; // see R15
         end else begin
            need_d = `DEBI_NEED_TWO; // see R10
         end
      end else if (i_req_ext && i_req_space == `DEBI_SP_DATA) begin
         if (!i_req_write) begin
            need_d = `DEBI_NEED_TWO; // see R17
         end else if (i_fetch_ext) begin
            need_d = `DEBI_NEED_TWO; // see R18 R19
         end else begin
            need_d = `DEBI_NEED_ONE; // see R18
         end
      end
   end

   wire is_ext = i_req_ext || (i_req_space == `DEBI_SP_IO); // see R11
   wire hold_req = !hold_n_s;
   // hold is only honoured at a machine cycle boundary between transfers
   wire take_hold = hold_req && cyc_end && (st_q == ST_RUN);
   assign o_core_ready = (st_q == ST_RUN) && cyc_end && !hold_req &&
                         !i_idle;
   assign o_dormant = (st_q == ST_IDLE) ||
                      ((st_q == ST_HOLD) && hold_halt_q);
   // o_exec_run stays high under hold when the halt bit is clear, but o_core_ready stays low
   assign o_exec_run = !o_dormant; // see R21
   assign o_hold_ack_n = !(st_q == ST_HOLD);
   // see R3 R4 R12 R22
   assign o_data_lines_oe = drv_q && (st_q == ST_XFER);
   assign o_address_lines_oe = (st_q != ST_HOLD); // see R3
   assign o_ctrl_oe = (st_q != ST_HOLD); // see R3

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= ST_RUN;
         cyc_q <= 2'h0;
         need_q <= `DEBI_NEED_ONE;
         ext_q <= 1'b0;
         drv_q <= 1'b0;
         hold_seen_q <= 1'b0;
         hold_halt_q <= `DEBI_HM_RESET;
         o_core_done <= 1'b0;
         o_core_rdata <= {`DEBI_DW{1'b0}};
         rd_q <= {`DEBI_DW{1'b0}};
         o_data_lines <= {`DEBI_DW{1'b0}};
         o_address_lines <= {`DEBI_AW{1'b0}};
         o_program_space_select_n <= 1'b1;
         o_data_space_select_n <= 1'b1;
         o_io_space_select_n <= 1'b1;
         o_transfer_strobe_n <= 1'b1;
         o_read_write <= 1'b1;
      end else begin
         o_core_done <= 1'b0;
         hold_seen_q <= hold_req;
         case (st_q)
            ST_RUN: begin
               if (take_hold) begin
                  hold_halt_q <= i_hold_halt_mode_bit; // see R1 R21
                  st_q <= ST_HOLD;
               end else if (cyc_end && i_idle) begin
                  st_q <= ST_IDLE; // see R1
               end else if (o_core_ready && i_req) begin
                  st_q <= ST_XFER;
                  cyc_q <= 2'h0;
                  need_q <= need_d;
                  ext_q <= is_ext;
                  drv_q <= is_ext && i_req_write;
                  o_read_write <= !(is_ext && i_req_write); // see R8
                  if (is_ext) begin
                     o_address_lines <= i_req_addr; // see R6 R9
                     o_data_lines <= i_req_wdata;
                     // see R7
                     o_program_space_select_n <=
                        !(i_req_space == `DEBI_SP_PROG);
                     o_data_space_select_n <=
                        !(i_req_space == `DEBI_SP_DATA);
                     o_io_space_select_n <= !(i_req_space == `DEBI_SP_IO);
                  end
               end
            end
            ST_XFER: begin
               // strobe low q2..q3 only, so it never glitches at edges
               o_transfer_strobe_n <= !(ext_q &&
                  (phase == `DEBI_PH_Q1 || phase == `DEBI_PH_Q2));
               // latch read data while the strobe is still low: the far
               // side may let the bus go as soon as the strobe rises
               if (ext_q && o_read_write && phase == `DEBI_PH_Q3) begin
                  rd_q <= i_data_lines; // see R6 R9
               end
               if (cyc_end) begin
                  if (ext_q && !ready_s) begin
                     cyc_q <= cyc_q; // see R13 R16
                  end else if (cyc_q + 2'h1 >= need_q) begin
                     st_q <= ST_RUN;
                     o_core_done <= 1'b1;
                     if (ext_q && o_read_write) begin
                        o_core_rdata <= rd_q;
                     end
                     // see R12: return selects and direction to inactive
                     o_program_space_select_n <= 1'b1;
                     o_data_space_select_n <= 1'b1;
                     o_io_space_select_n <= 1'b1;
                     o_read_write <= 1'b1;
                     drv_q <= 1'b0;
                  end else begin
                     cyc_q <= cyc_q + 2'h1;
                  end
               end
            end
            ST_IDLE: begin
               // address and controls keep their steady levels
               if (i_interrupt) begin
                  st_q <= ST_RUN; // see R5 R2
               end
            end
            ST_HOLD: begin
               o_transfer_strobe_n <= 1'b1; // see R22
               if (!hold_req && !hold_seen_q) begin
                  st_q <= ST_RUN; // see R5 R2
               end
            end
            default: begin
               st_q <= ST_RUN;
            end
         endcase
      end
   end
endmodule

// file: testbench/debi_bus_if_sva.sv
// assertion checker for the external bus interface pins
module debi_bus_if_sva (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_hold_halt_mode_bit,
   input wire o_core_done,
   input wire o_exec_run,
   input wire o_dormant,
   input wire o_data_lines_oe,
   input wire [15:0] o_address_lines,
   input wire o_address_lines_oe,
   input wire o_program_space_select_n,
   input wire o_data_space_select_n,
   input wire o_io_space_select_n,
   input wire o_transfer_strobe_n,
   input wire o_read_write,
   input wire o_ctrl_oe,
   input wire o_hold_ack_n,
   input wire o_phase_clock_out_a,
   input wire o_phase_clock_out_b
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire [2:0] sel = {o_program_space_select_n, o_data_space_select_n,
      o_io_space_select_n};
   a_one_select: assert property (
      !o_transfer_strobe_n |-> $countones(sel) == 2)
      else $error("select not unique");
   a_halt_float: assert property (
      !o_hold_ack_n |->
      !o_data_lines_oe && !o_address_lines_oe && !o_ctrl_oe)
      else $error("bus driven in hold");
   a_halt_stop: assert property (
      !o_hold_ack_n && i_hold_halt_mode_bit |-> !o_exec_run)
      else $error("running in hold halt");
   a_idle_float: assert property (
      o_dormant && o_hold_ack_n |->
      !o_data_lines_oe && o_address_lines_oe && o_ctrl_oe)
      else $error("idle drive wrong");
   a_idle_steady: assert property (
      o_dormant && $past(o_dormant) && o_hold_ack_n |->
      $stable(o_address_lines) && $stable(sel))
      else $error("idle outputs moved");
   a_quiet_dormant: assert property (
      o_dormant |-> o_transfer_strobe_n)
      else $error("strobe while dormant");
   a_done_pulse: assert property (
      o_core_done |=> !o_core_done)
      else $error("done too long");
   a_addr_hold: assert property (
      !o_transfer_strobe_n ##1 !o_transfer_strobe_n |->
      $stable(o_address_lines) && $stable(o_read_write))
      else $error("address moved in strobe");
   a_phase_period: assert property (
      $rose(o_phase_clock_out_a) |-> ##4 $rose(o_phase_clock_out_a))
      else $error("phase period wrong");
   a_phase_pair: assert property (
      o_phase_clock_out_b == $past(o_phase_clock_out_a))
      else $error("phase clocks out of step");
   a_write_drive: assert property (
      o_data_lines_oe |-> !o_read_write)
      else $error("data driven on read");
   c_hold: cover property (!o_hold_ack_n);
   c_idle: cover property (o_dormant && o_hold_ack_n);
   c_io: cover property (!o_transfer_strobe_n && !o_io_space_select_n);
endmodule
bind debi_bus_if debi_bus_if_sva i_sva (.*);

// file: testbench/debi_ext_mem.sv
// external memory and port model on the far side of the bus
module debi_ext_mem (
   input wire i_clk,
   input wire [15:0] o_address_lines,
   input wire [15:0] o_data_lines,
   input wire o_program_space_select_n,
   input wire o_data_space_select_n,
   input wire o_io_space_select_n,
   input wire o_transfer_strobe_n,
   input wire o_read_write,
   input int waits,
   output logic [15:0] i_data_lines,
   output logic i_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:31];
   logic [15:0] held = 16'h0000;
   int cnt = 0;
   // ports live apart from data words only through the select
   wire [4:0] idx = {~o_io_space_select_n, o_address_lines[3:0]};
   wire rd_on = !o_transfer_strobe_n && o_read_write;
   // an access is open from take to done, whichever space it targets
   wire busy = !(o_program_space_select_n && o_data_space_select_n &&
      o_io_space_select_n);
   always @(posedge i_clk) begin
      cnt <= busy ? cnt + 1 : 0;
      if (!o_transfer_strobe_n && !o_read_write) mem[idx] <= o_data_lines;
      if (rd_on) held <= mem[idx];
   end
   // released bus shows the inverse so a stale value never passes
   assign i_data_lines = rd_on ? mem[idx] : ~held;
   // slow mode keeps ready low until the wait count has run; whole clocks
   // of the access count, since the strobe pulses once per machine cycle
   assign i_ready = waits == 0 || (busy && cnt >= waits);
endmodule

// file: testbench/debi_bus_if_tb_top.sv
// self-checking bench for the external bus interface
`include "debi_regs.vh"
module debi_bus_if_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_rst_n = 0, i_req = 0, i_req_write = 0, i_req_ext = 0;
   logic i_req_repeat = 0, i_fetch_ext = 0, i_hold_halt_mode_bit = 1;
   logic i_idle = 0, i_interrupt = 0, i_hold_n = 1, i_ready, transfer_strobe;
   logic [1:0] i_req_space = 0;
   logic [15:0] i_req_addr = 0, i_req_wdata = 0, i_data_lines, rd;
   logic [15:0] o_core_rdata, o_data_lines, o_address_lines;
   logic o_core_ready, o_core_done, o_exec_run, o_dormant, o_data_lines_oe;
   logic o_address_lines_oe, o_program_space_select_n, o_data_space_select_n;
   logic o_io_space_select_n, o_transfer_strobe_n, o_read_write, o_ctrl_oe;
   logic o_hold_ack_n, o_phase_clock_out_a, o_phase_clock_out_b;
   int fail_count = 0, checked = 0, waits = 0, n, m, cyc;
   debi_bus_if i_dut (.*);
   debi_ext_mem i_mem (.*);
   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) if (!o_transfer_strobe_n) transfer_strobe = 1;
   task test_done;
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(string s, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task tmo;
      if (n >= 100) begin
         fail_count++;
         test_done;
      end
   endtask
   // f is {write, external, repeat, next fetch external}
   task acc(logic [1:0] sp, logic [3:0] f, logic [15:0] a);
      @(posedge i_clk);
      i_req <= 1;
      {i_req_write, i_req_ext, i_req_repeat, i_fetch_ext} <= f;
      {i_req_space, i_req_addr, i_req_wdata} <= {sp, a, 16'hC3C3};
      m = -1;
      n = 0;
      while (!o_core_done && n < 100) begin
         @(posedge i_clk);
         if (m < 0 && o_core_ready) m = n;
         n++;
         #1;
      end
      tmo;
      cyc = n - 1 - m;
      rd = o_core_rdata;
      @(posedge i_clk) i_req <= 0;
   endtask
   task t_cyc;
      logic [1:0] sp [7] = '{1, 1, 1, 2, 2, 2, 1};
      logic [3:0] f [7] = '{12, 13, 4, 12, 14, 4, 0};
      int ex [7] = '{4, 8, 8, 4, 4, 8, 4};
      for (int i = 0; i < 7; i++) begin
         transfer_strobe = 0;
         acc(sp[i], f[i], 16'h0005 + 16'(sp[i] * 10));
         chk("cycles", 16'(cyc), 16'(ex[i]));
         if (i == 2 || i == 5) chk("read", rd, 16'hC3C3);
      end
      chk("internal strobe", 16'(transfer_strobe), 16'h0000);
   endtask
   task t_wait;
      waits = 5;
      acc(`DEBI_SP_DATA, 4'h4, 16'h000F);
      chk("wait cycles", 16'(cyc >= 12), 16'h0001);
      chk("wait read", rd, 16'hC3C3);
      waits = 0;
   endtask
   task t_hold;
      @(posedge i_clk) i_hold_n <= 0;
      for (n = 0; n < 100 && o_hold_ack_n; n++) @(posedge i_clk) #1;
      tmo;
      chk("hold oe", 16'({o_data_lines_oe, o_address_lines_oe, o_ctrl_oe,
         o_exec_run}), 16'h0000);
      @(posedge i_clk) i_hold_n <= 1;
      for (n = 0; n < 100 && o_dormant; n++) @(posedge i_clk) #1;
      tmo;
      acc(`DEBI_SP_IO, 4'h4, 16'h0019);
      chk("after hold", rd, 16'hC3C3);
   endtask
   task t_idle;
      @(posedge i_clk) i_idle <= 1;
      for (n = 0; n < 100 && !o_dormant; n++) @(posedge i_clk) #1;
      tmo;
      chk("idle oe", 16'({o_data_lines_oe, o_address_lines_oe, o_ctrl_oe}),
         16'h0003);
      // the idle instruction is spent once dormant, so the core drops it
      @(posedge i_clk) begin
         i_idle <= 0;
         i_interrupt <= 1;
      end
      for (n = 0; n < 100 && o_dormant; n++) @(posedge i_clk) #1;
      tmo;
      @(posedge i_clk) i_interrupt <= 0;
      acc(`DEBI_SP_DATA, 4'h4, 16'h000F);
      chk("after idle", rd, 16'hC3C3);
   endtask
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1;
      repeat (8) @(posedge i_clk);
      t_cyc;
      t_wait;
      t_hold;
      t_idle;
      test_done;
   end
endmodule
